// *** fuse_store_map.svh ***
`ifndef FUSE_STORE_MAP_SVH
`define FUSE_STORE_MAP_SVH
// Function
// RQ1: programmed fuse reads zero, unprogrammed fuse reads one.
// RQ2: exactly three fuse bytes: extended, high and low.
// RQ3: extended bit 0 enables self programming; bits 7..1 unused, read one.
// RQ4: high byte: reset disable, debug link, serial download, watchdog, eeprom, brownout.
// RQ5: low byte: divide by eight, clock out, startup time, unused, clock source.
// RQ6: default clock source 2'b10 selects internal 8 MHz oscillator.
// RQ7: serial download fuse cannot be accessed in serial programming mode.
// RQ8: reset-disable or debug fuse blocks serial programming; only parallel unprograms.
// RQ9: clock output fuse drives system clock onto port B bit zero.
// RQ10: chip erase leaves every fuse bit unchanged.
// RQ11: programmed lock bit one refuses any fuse change.
// RQ12: programmer should write fuses before programming lock bits.
// RQ13: fuses latched on programming entry; changes apply after leaving it.
// RQ14: eeprom preserve fuse takes effect immediately once programmed.
// RQ15: all fuses also latched at power-up in normal mode.
// RQ16: three signature bytes at 0x000..0x002, readable even when locked.
// RQ17: calibration byte sits in high byte of signature address 0x000.
// RQ18: every reset copies calibration byte into oscillator calibration register.
// RQ19: flash pages of 32 words; word PC[4:0], page PC[10:5] or PC[11:5].
// RQ20: eeprom 16 pages of 4 bytes; byte addr[1:0], page addr[5:2].
// RQ21: store program memory enabled for whole flash only if fuse is zero.
// RQ22: latched fuse outputs stay stable between latch events.
`define FUSE_EXT_DEFAULT      8'hFF
`define FUSE_HIGH_DEFAULT     8'hDF
`define FUSE_LOW_DEFAULT      8'h6E
`define FUSE_EXT_UNUSED_MASK  8'hFE
`define FUSE_LOW_UNUSED_MASK  8'h0C
`define FUSE_SELFPRG_BIT      0
`define FUSE_RSTDIS_BIT       7
`define FUSE_DEBUG_BIT        6
`define FUSE_SERIAL_BIT       5
`define FUSE_WDT_BIT          4
`define FUSE_EEPRES_BIT       3
`define FUSE_BOD_MSB          2
`define FUSE_DIV8_BIT         7
`define FUSE_CLKOUT_BIT       6
`define FUSE_SUT_MSB          5
`define FUSE_SUT_LSB          4
`define FUSE_CKSEL_MSB        1
`define CKSEL_INTERNAL_8MHZ   2'h2
`define SIG_ADDR_0            2'h0
`define SIG_ADDR_1            2'h1
`define SIG_ADDR_2            2'h2
`define SIG_BYTE_0            8'hA5
`define SIG_BYTE_1            8'h5A
`define SIG_BYTE_2            8'h3C
`define CAL_DEFAULT           8'h80
`define FLASH_WORD_MSB        4
`define FLASH_PAGE_LSB        5
`define EE_BYTE_MSB           1
`define EE_PAGE_LSB           2
`define EE_PAGE_MSB           5
`endif

// *** fuse_store_pkg.sv ***
package fuse_store_pkg;
  typedef enum logic [1:0] {
    SEL_EXT  = 2'b00,
    SEL_HIGH = 2'b01,
    SEL_LOW  = 2'b10
  } fuse_sel_e;
  typedef enum logic [1:0] {
    MODE_NORMAL   = 2'b00,
    MODE_SERIAL   = 2'b01,
    MODE_PARALLEL = 2'b10
  } prog_mode_e;
endpackage

// *** fuse_page_split.sv ***
`timescale 1ns/10ps
`include "fuse_store_map.svh"
module fuse_page_split (
  // addresses
  input  wire logic [11:0] i_pc,
  input  wire logic [5:0]  i_ee_addr,
  // flash split
  output logic      [4:0]  o_word_in_page_field,
  output logic      [6:0]  o_page_number_field,
  // eeprom split
  output logic      [1:0]  o_ee_byte,
  output logic      [3:0]  o_ee_page
);
  assign o_word_in_page_field = i_pc[`FLASH_WORD_MSB:0]; // RQ19
  assign o_page_number_field  = i_pc[11:`FLASH_PAGE_LSB]; // RQ19
  assign o_ee_byte = i_ee_addr[`EE_BYTE_MSB:0]; // RQ20
  assign o_ee_page = i_ee_addr[`EE_PAGE_MSB:`EE_PAGE_LSB]; // RQ20
endmodule

// *** fuse_signature_config_store.sv ***
`timescale 1ns/10ps
`include "fuse_store_map.svh"
module fuse_signature_config_store #(
  // identification bytes: values arbitrary
  parameter logic [7:0] SIG0 = `SIG_BYTE_0,
  parameter logic [7:0] SIG1 = `SIG_BYTE_1,
  parameter logic [7:0] SIG2 = `SIG_BYTE_2,
  parameter logic [7:0] CAL  = `CAL_DEFAULT,
  // 0: small part (page PC[10:5]); 1: large part (page PC[11:5])
  parameter bit         LARGE_PART = 1'b1
) (
  // clock and reset
  input  wire logic        I_REF_CLK,
  input  wire logic        I_SRST,
  input  wire logic        I_POWER_UP,
  // programmer access
  input  wire logic [1:0]  I_MODE,
  input  wire logic        I_FUSE_WR,
  input  wire logic [1:0]  I_FUSE_SEL,
  input  wire logic [7:0]  I_FUSE_WDATA,
  input  wire logic        I_LOCK_BIT_ONE,
  input  wire logic        I_CHIP_ERASE,
  input  wire logic [1:0]  I_SIG_ADDR,
  input  wire logic        I_SIG_HIGH,
  // page addressing
  input  wire logic [11:0] I_PC,
  input  wire logic [5:0]  I_EEPROM_ADDRESS,
  // readback
  output logic      [7:0]  O_FUSE_EXTENDED_BYTE,
  output logic      [7:0]  O_FUSE_HIGH_BYTE,
  output logic      [7:0]  O_FUSE_LOW_BYTE,
  output logic      [7:0]  O_SIG_RDATA,
  output logic             O_FUSE_WR_REFUSED,
  // latched configuration, except eeprom preserve, which follows its cell
  output logic             O_SELF_PROGRAM_ENABLE,
  output logic             O_EXTERNAL_RESET_DISABLE,
  output logic             O_DEBUG_LINK_ENABLE,
  output logic             O_SERIAL_DOWNLOAD_ENABLE,
  output logic             O_WATCHDOG_ALWAYS_ON,
  output logic             O_EEPROM_PRESERVE,
  output logic      [2:0]  O_BROWNOUT_LEVEL,
  output logic             O_CLOCK_DIVIDE_BY_EIGHT,
  output logic             O_CLOCK_OUTPUT_ENABLE,
  output logic      [1:0]  O_STARTUP_TIME,
  output logic      [1:0]  O_CLOCK_SOURCE,
  output logic             O_INTERNAL_OSC_8MHZ,
  output logic             O_SERIAL_PROG_BLOCKED,
  output logic             O_PORT_B_BIT_ZERO_CLOCK,
  output logic      [7:0]  O_OSCILLATOR_CALIBRATION_REGISTER,
  // page split
  output logic      [4:0]  O_WORD_IN_PAGE_FIELD,
  output logic      [6:0]  O_PAGE_NUMBER_FIELD,
  output logic      [1:0]  O_EEPROM_BYTE_IN_PAGE,
  output logic      [3:0]  O_EEPROM_PAGE
);
  // non-volatile cells
  logic [7:0] cell_ext;
  logic [7:0] cell_high;
  logic [7:0] cell_low;
  // latched copies seen by the rest of the chip
  logic [7:0] lat_ext;
  logic [7:0] lat_high;
  logic [7:0] lat_low;
  logic [1:0] mode_prev;
  logic       prog_entry;
  logic       prog_exit;
  logic       in_serial;
  logic       wr_allowed;
  logic [7:0] wmask;
  logic [7:0] next_cell;
  logic [6:0] page_full;

  assign in_serial = (I_MODE == fuse_store_pkg::MODE_SERIAL);
  assign prog_entry = (mode_prev == fuse_store_pkg::MODE_NORMAL) &&
                      (I_MODE != fuse_store_pkg::MODE_NORMAL);
  assign prog_exit  = (mode_prev != fuse_store_pkg::MODE_NORMAL) &&
                      (I_MODE == fuse_store_pkg::MODE_NORMAL);
  // lock bit one programmed (zero) locks fuses; writes only in a prog mode
  assign wr_allowed = I_LOCK_BIT_ONE &&
                      (I_MODE != fuse_store_pkg::MODE_NORMAL); // RQ11
  assign O_FUSE_WR_REFUSED = I_FUSE_WR && !wr_allowed; // RQ11

  // per-byte write masks; unused bits can never be programmed
  always_comb begin
    wmask     = 8'hFF;
    next_cell = I_FUSE_WDATA;
    if (I_FUSE_SEL == fuse_store_pkg::SEL_EXT) begin
      next_cell = I_FUSE_WDATA | `FUSE_EXT_UNUSED_MASK; // RQ3
    end else if (I_FUSE_SEL == fuse_store_pkg::SEL_HIGH) begin
      if (in_serial) begin
        wmask[`FUSE_SERIAL_BIT] = 1'b0; // RQ7
        // serial may not unprogram reset-disable or debug bits
        next_cell[`FUSE_RSTDIS_BIT] = I_FUSE_WDATA[`FUSE_RSTDIS_BIT] &
                                      cell_high[`FUSE_RSTDIS_BIT]; // RQ8
        next_cell[`FUSE_DEBUG_BIT]  = I_FUSE_WDATA[`FUSE_DEBUG_BIT] &
                                      cell_high[`FUSE_DEBUG_BIT]; // RQ8
      end
    end else begin
      next_cell = I_FUSE_WDATA | `FUSE_LOW_UNUSED_MASK; // RQ5
    end
  end

  // chip erase deliberately has no path into the cells
  always_ff @(posedge I_REF_CLK) begin
    if (I_POWER_UP) begin
      cell_ext  <= `FUSE_EXT_DEFAULT; // RQ3
      cell_high <= `FUSE_HIGH_DEFAULT; // RQ4
      cell_low  <= `FUSE_LOW_DEFAULT; // RQ5 RQ6
    end else if (I_FUSE_WR && wr_allowed) begin // RQ10
      if (I_FUSE_SEL == fuse_store_pkg::SEL_EXT) begin
        cell_ext <= next_cell;
      end else if (I_FUSE_SEL == fuse_store_pkg::SEL_HIGH) begin
        cell_high <= (next_cell & wmask) | (cell_high & ~wmask);
      end else if (I_FUSE_SEL == fuse_store_pkg::SEL_LOW) begin
        cell_low <= next_cell;
      end
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_POWER_UP || I_SRST) begin
      mode_prev <= fuse_store_pkg::MODE_NORMAL;
    end else begin
      mode_prev <= I_MODE;
    end
  end

  // latch at power-up, programming entry and exit; hold otherwise
  always_ff @(posedge I_REF_CLK) begin
    if (I_POWER_UP) begin
      lat_ext  <= `FUSE_EXT_DEFAULT; // RQ15
      lat_high <= `FUSE_HIGH_DEFAULT; // RQ15
      lat_low  <= `FUSE_LOW_DEFAULT; // RQ15
    end else if (prog_entry || prog_exit) begin // RQ13
      lat_ext  <= cell_ext;
      lat_high <= cell_high;
      lat_low  <= cell_low;
    end // RQ22
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_POWER_UP || I_SRST) begin
      O_OSCILLATOR_CALIBRATION_REGISTER <= CAL; // RQ18
    end
  end

  // signature space: address 0 high byte is calibration
  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      O_SIG_RDATA <= 8'h00;
    end else if (I_SIG_ADDR == `SIG_ADDR_0) begin
      O_SIG_RDATA <= I_SIG_HIGH ? CAL : SIG0; // RQ16 RQ17
    end else if (I_SIG_ADDR == `SIG_ADDR_1) begin
      O_SIG_RDATA <= SIG1; // RQ16
    end else if (I_SIG_ADDR == `SIG_ADDR_2) begin
      O_SIG_RDATA <= SIG2; // RQ16
    end else begin
      O_SIG_RDATA <= 8'hFF;
    end
  end

  // readback of cells: zero means programmed
  assign O_FUSE_EXTENDED_BYTE = cell_ext; // RQ1 RQ2
  assign O_FUSE_HIGH_BYTE     = cell_high; // RQ1 RQ2
  assign O_FUSE_LOW_BYTE      = cell_low; // RQ1 RQ2

  assign O_SELF_PROGRAM_ENABLE    = !lat_ext[`FUSE_SELFPRG_BIT]; // RQ21
  assign O_EXTERNAL_RESET_DISABLE = !lat_high[`FUSE_RSTDIS_BIT]; // RQ4
  assign O_DEBUG_LINK_ENABLE      = !lat_high[`FUSE_DEBUG_BIT]; // RQ4
  assign O_SERIAL_DOWNLOAD_ENABLE = !lat_high[`FUSE_SERIAL_BIT]; // RQ4
  assign O_WATCHDOG_ALWAYS_ON     = !lat_high[`FUSE_WDT_BIT]; // RQ4
  // preserve acts from the cell directly, without waiting for a latch
  assign O_EEPROM_PRESERVE        = !cell_high[`FUSE_EEPRES_BIT]; // RQ14
  assign O_BROWNOUT_LEVEL         = lat_high[`FUSE_BOD_MSB:0]; // RQ4
  assign O_CLOCK_DIVIDE_BY_EIGHT  = !lat_low[`FUSE_DIV8_BIT]; // RQ5
  assign O_CLOCK_OUTPUT_ENABLE    = !lat_low[`FUSE_CLKOUT_BIT]; // RQ5
  assign O_STARTUP_TIME = lat_low[`FUSE_SUT_MSB:`FUSE_SUT_LSB]; // RQ5
  assign O_CLOCK_SOURCE = lat_low[`FUSE_CKSEL_MSB:0]; // RQ5
  assign O_INTERNAL_OSC_8MHZ =
    (lat_low[`FUSE_CKSEL_MSB:0] == `CKSEL_INTERNAL_8MHZ); // RQ6
  assign O_SERIAL_PROG_BLOCKED =
    O_EXTERNAL_RESET_DISABLE || O_DEBUG_LINK_ENABLE; // RQ8
  assign O_PORT_B_BIT_ZERO_CLOCK =
    O_CLOCK_OUTPUT_ENABLE && I_REF_CLK; // RQ9

  fuse_page_split u_split (
    .i_pc                 (I_PC),
    .i_ee_addr            (I_EEPROM_ADDRESS),
    .o_word_in_page_field (O_WORD_IN_PAGE_FIELD),
    .o_page_number_field  (page_full),
    .o_ee_byte            (O_EEPROM_BYTE_IN_PAGE),
    .o_ee_page            (O_EEPROM_PAGE)
  );
  // small part has 64 pages, top page bit forced to zero
  assign O_PAGE_NUMBER_FIELD = LARGE_PART ? page_full
                                          : {1'b0, page_full[5:0]}; // RQ19
endmodule

// *** fuse_store_props.sv ***
`timescale 1ns/10ps
module fuse_store_props #(
  parameter logic [7:0] CAL = 8'h00
) (
  input wire logic        I_REF_CLK, I_SRST, I_POWER_UP, I_FUSE_WR,
  input wire logic        I_LOCK_BIT_ONE, I_CHIP_ERASE, I_SIG_HIGH,
  input wire logic [1:0]  I_MODE, I_FUSE_SEL, I_SIG_ADDR, O_CLOCK_SOURCE,
  input wire logic [7:0]  O_FUSE_EXTENDED_BYTE, O_FUSE_HIGH_BYTE,
  input wire logic [7:0]  O_FUSE_LOW_BYTE, O_SIG_RDATA,
  input wire logic        O_FUSE_WR_REFUSED, O_SELF_PROGRAM_ENABLE,
  input wire logic        O_EEPROM_PRESERVE, O_INTERNAL_OSC_8MHZ,
  input wire logic [11:0] I_PC,
  input wire logic [5:0]  I_EEPROM_ADDRESS,
  input wire logic [4:0]  O_WORD_IN_PAGE_FIELD,
  input wire logic [6:0]  O_PAGE_NUMBER_FIELD,
  input wire logic [1:0]  O_EEPROM_BYTE_IN_PAGE,
  input wire logic [3:0]  O_EEPROM_PAGE
);
  wire logic [23:0] cells = {O_FUSE_EXTENDED_BYTE, O_FUSE_HIGH_BYTE,
                             O_FUSE_LOW_BYTE};
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (I_SRST);
  chk_refuse_flag: assert property (
    O_FUSE_WR_REFUSED == (I_FUSE_WR && (!I_LOCK_BIT_ONE || I_MODE == 2'h0)))
    else $error("refuse flag wrong");
  chk_refused_keeps: assert property (
    O_FUSE_WR_REFUSED && !I_POWER_UP |=> $stable(cells))
    else $error("refused write changed a fuse");
  chk_unused_ones: assert property (
    O_FUSE_EXTENDED_BYTE[7:1] == 7'h7F && O_FUSE_LOW_BYTE[3:2] == 2'h3)
    else $error("unused fuse bit not one");
  chk_latch_hold: assert property (
    ((I_MODE == 2'h0) == ($past(I_MODE) == 2'h0)) && !I_POWER_UP
    |=> $stable(O_CLOCK_SOURCE) && $stable(O_SELF_PROGRAM_ENABLE))
    else $error("latched fuse moved between latch events");
  chk_latch_copy: assert property (
    ((I_MODE == 2'h0) != ($past(I_MODE) == 2'h0)) && !I_POWER_UP
    |=> O_CLOCK_SOURCE == $past(O_FUSE_LOW_BYTE[1:0])
    && O_SELF_PROGRAM_ENABLE == !$past(O_FUSE_EXTENDED_BYTE[0]))
    else $error("latch did not copy cells");
  chk_eeprom_live: assert property (
    O_EEPROM_PRESERVE == !O_FUSE_HIGH_BYTE[3])
    else $error("eeprom preserve not live");
  chk_osc_select: assert property (
    O_INTERNAL_OSC_8MHZ == (O_CLOCK_SOURCE == 2'h2))
    else $error("internal oscillator select wrong");
  chk_serial_guard: assert property (
    I_FUSE_WR && !O_FUSE_WR_REFUSED && I_MODE == 2'h1 && I_FUSE_SEL == 2'h1
    && !I_POWER_UP |=> O_FUSE_HIGH_BYTE[5] == $past(O_FUSE_HIGH_BYTE[5])
    && (O_FUSE_HIGH_BYTE[7:6] & ~$past(O_FUSE_HIGH_BYTE[7:6])) == 2'h0)
    else $error("serial write broke guarded bits");
  chk_cal_read: assert property (
    I_SIG_ADDR == 2'h0 && I_SIG_HIGH |=> O_SIG_RDATA == CAL)
    else $error("calibration byte read wrong");
  chk_page_split: assert property (
    O_WORD_IN_PAGE_FIELD == I_PC[4:0] && O_PAGE_NUMBER_FIELD == I_PC[11:5]
    && O_EEPROM_BYTE_IN_PAGE == I_EEPROM_ADDRESS[1:0]
    && O_EEPROM_PAGE == I_EEPROM_ADDRESS[5:2])
    else $error("page split wrong");
  cov_refused: cover property (O_FUSE_WR_REFUSED);
  cov_serial_wr: cover property (I_FUSE_WR && I_MODE == 2'h1);
  cov_erase: cover property (I_CHIP_ERASE);
endmodule
bind fuse_signature_config_store fuse_store_props #(.CAL(CAL)) props_inst (.*);

// *** fuse_programmer_model.sv ***
`timescale 1ns/10ps
module fuse_programmer_model (
  // clock
  input  wire logic       i_clk,
  // programmer drive
  output logic      [1:0] o_mode,
  output logic            o_wr,
  output logic      [1:0] o_sel,
  output logic      [7:0] o_wdata
);
  initial begin
    o_mode = 2'h0;
    o_wr = 1'b0;
    o_sel = 2'h0;
    o_wdata = 8'hFF;
  end
  // two edges: mode_prev takes the mode and the latch lands on the first; the second is spare
  task automatic set_mode(input logic [1:0] m);
    @(posedge i_clk);
    o_mode <= m;
    repeat (2) @(posedge i_clk);
  endtask
  // data goes inverse after the strobe so a late sample shows up
  task automatic put_fuse(input logic [1:0] s, input logic [7:0] d);
    @(posedge i_clk);
    o_wr <= 1'b1;
    o_sel <= s;
    o_wdata <= d;
    @(posedge i_clk);
    o_wr <= 1'b0;
    o_wdata <= ~d;
  endtask
endmodule

// *** testbench.sv ***
`timescale 1ns/10ps
`include "fuse_store_map.svh"
module testbench;
  logic I_REF_CLK, I_SRST, I_POWER_UP, I_FUSE_WR, I_LOCK_BIT_ONE;
  logic I_CHIP_ERASE, I_SIG_HIGH, O_FUSE_WR_REFUSED, O_SELF_PROGRAM_ENABLE;
  logic [1:0] I_MODE, I_FUSE_SEL, I_SIG_ADDR, O_STARTUP_TIME, O_CLOCK_SOURCE;
  logic [1:0] O_EEPROM_BYTE_IN_PAGE;
  logic [2:0] O_BROWNOUT_LEVEL;
  logic [3:0] O_EEPROM_PAGE;
  logic [4:0] O_WORD_IN_PAGE_FIELD;
  logic [5:0] I_EEPROM_ADDRESS;
  logic [6:0] O_PAGE_NUMBER_FIELD;
  logic [11:0] I_PC;
  logic [7:0] I_FUSE_WDATA, O_FUSE_EXTENDED_BYTE, O_FUSE_HIGH_BYTE;
  logic [7:0] O_FUSE_LOW_BYTE, O_SIG_RDATA, O_OSCILLATOR_CALIBRATION_REGISTER;
  logic O_EXTERNAL_RESET_DISABLE, O_DEBUG_LINK_ENABLE, O_WATCHDOG_ALWAYS_ON;
  logic O_SERIAL_DOWNLOAD_ENABLE, O_EEPROM_PRESERVE, O_CLOCK_DIVIDE_BY_EIGHT;
  logic O_CLOCK_OUTPUT_ENABLE, O_INTERNAL_OSC_8MHZ, O_SERIAL_PROG_BLOCKED;
  logic O_PORT_B_BIT_ZERO_CLOCK;
  int err_total, compares, cyc, refusals;
  typedef struct {logic [1:0] sel; logic [7:0] d; logic [7:0] e;} row_s;
  row_s rows [6] = '{'{2'h2, 8'h00, 8'h0C}, '{2'h1, 8'h00, 8'h00},
    '{2'h0, 8'hFF, 8'hFF}, '{2'h1, 8'hF7, 8'hF7}, '{2'h0, 8'h00, 8'hFE},
    '{2'h2, 8'h80, 8'h8C}};
  logic [7:0] sig_exp [5] = '{`SIG_BYTE_0, `SIG_BYTE_1, `SIG_BYTE_2, 8'hFF,
    `CAL_DEFAULT};
  wire logic [23:0] cells = {O_FUSE_LOW_BYTE, O_FUSE_HIGH_BYTE,
                             O_FUSE_EXTENDED_BYTE};
  fuse_signature_config_store fuse_signature_config_store_inst (.*);
  fuse_programmer_model fuse_programmer_model_inst (.i_clk(I_REF_CLK),
    .o_mode(I_MODE), .o_wr(I_FUSE_WR), .o_sel(I_FUSE_SEL),
    .o_wdata(I_FUSE_WDATA));
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    I_REF_CLK = 1'b0;
    forever #12.5 I_REF_CLK = ~I_REF_CLK;
  end
  always @(posedge I_REF_CLK) begin
    cyc++;
    refusals += (O_FUSE_WR_REFUSED === 1'b1);
    if (cyc == 1000) begin
      err_total++;
      wrap_up();
    end
  end
  initial begin
    I_SRST = 1'b1;
    I_POWER_UP = 1'b1;
    I_LOCK_BIT_ONE = 1'b1;
    I_CHIP_ERASE = 1'b0;
    I_SIG_ADDR = 2'h0;
    I_SIG_HIGH = 1'b0;
    I_PC = 12'hABC;
    I_EEPROM_ADDRESS = 6'h2D;
    @(posedge I_REF_CLK) I_POWER_UP <= 1'b0;
    repeat (4) @(posedge I_REF_CLK);
    I_SRST <= 1'b0;
    @(posedge I_REF_CLK) #1;
    chk("defaults", cells[23:16], 8'h6E);
    chk("defaults high", cells[15:8], 8'hDF);
    chk("defaults ext", cells[7:0], 8'hFF);
    chk("bod sut", {3'h0, O_BROWNOUT_LEVEL, O_STARTUP_TIME}, 8'h1E);
    chk("config", {3'h0, O_CLOCK_DIVIDE_BY_EIGHT, O_SERIAL_DOWNLOAD_ENABLE,
      O_INTERNAL_OSC_8MHZ, O_SELF_PROGRAM_ENABLE, O_WATCHDOG_ALWAYS_ON},
      8'h1C);
    chk("calreg", O_OSCILLATOR_CALIBRATION_REGISTER, `CAL_DEFAULT);
    chk("word", {3'h0, O_WORD_IN_PAGE_FIELD}, 8'h1C);
    chk("page", {1'b0, O_PAGE_NUMBER_FIELD}, 8'h55);
    chk("eesplit", {O_EEPROM_PAGE, 2'h0, O_EEPROM_BYTE_IN_PAGE}, 8'hB1);
    $display("test defaults done");
    fuse_programmer_model_inst.set_mode(2'h2);
    foreach (rows[i]) begin
      fuse_programmer_model_inst.put_fuse(rows[i].sel, rows[i].d);
      #1 chk("row", cells[rows[i].sel*8 +: 8], rows[i].e);
    end
    $display("test rows done");
    chk("held", {3'h0, O_CLOCK_SOURCE, O_INTERNAL_OSC_8MHZ,
      O_SELF_PROGRAM_ENABLE, O_CLOCK_OUTPUT_ENABLE}, 8'h14);
    chk("eeprom_preserve", {7'h0, O_EEPROM_PRESERVE}, 8'h01);
    fuse_programmer_model_inst.set_mode(2'h0);
    #1 chk("latched", {3'h0, O_CLOCK_SOURCE, O_INTERNAL_OSC_8MHZ,
      O_SELF_PROGRAM_ENABLE, O_CLOCK_OUTPUT_ENABLE}, 8'h03);
    @(posedge I_REF_CLK) #5;
    chk("pb0", {7'h0, O_PORT_B_BIT_ZERO_CLOCK}, 8'h01);
    #13 chk("pb0 low", {7'h0, O_PORT_B_BIT_ZERO_CLOCK}, 8'h00);
    $display("test latch done");
    // mid-run reset in normal mode: fuses and latches must ride through it
    @(posedge I_REF_CLK) I_SRST <= 1'b1;
    @(posedge I_REF_CLK) I_SRST <= 1'b0;
    #1 chk("srst sig", O_SIG_RDATA, 8'h00);
    chk("srst cells", cells[7:0], 8'hFE);
    chk("srst cal", O_OSCILLATOR_CALIBRATION_REGISTER, `CAL_DEFAULT);
    $display("test reset done");
    fuse_programmer_model_inst.set_mode(2'h1);
    fuse_programmer_model_inst.put_fuse(2'h1, 8'h00);
    #1 chk("serial", O_FUSE_HIGH_BYTE, 8'h20);
    fuse_programmer_model_inst.put_fuse(2'h1, 8'hFF);
    #1 chk("serial", O_FUSE_HIGH_BYTE, 8'h3F);
    fuse_programmer_model_inst.set_mode(2'h0);
    #1 chk("blocked", {5'h0, O_EXTERNAL_RESET_DISABLE, O_DEBUG_LINK_ENABLE,
      O_SERIAL_PROG_BLOCKED}, 8'h07);
    fuse_programmer_model_inst.set_mode(2'h2);
    fuse_programmer_model_inst.put_fuse(2'h1, 8'hDF);
    #1 chk("parallel", O_FUSE_HIGH_BYTE, 8'hDF);
    $display("test serial done");
    // fuses are final before the lock goes on
    @(posedge I_REF_CLK) I_LOCK_BIT_ONE <= 1'b0;
    I_CHIP_ERASE <= 1'b1;
    fuse_programmer_model_inst.put_fuse(2'h0, 8'hFF);
    @(posedge I_REF_CLK) #1;
    chk("locked", O_FUSE_EXTENDED_BYTE, 8'hFE);
    chk("refusals", 8'(refusals), 8'h01);
    I_CHIP_ERASE <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      @(posedge I_REF_CLK);
      I_SIG_ADDR <= 2'(i % 4);
      I_SIG_HIGH <= (i == 4);
      @(posedge I_REF_CLK) #1;
      chk("signature", O_SIG_RDATA, sig_exp[i]);
    end
    $display("test lock done");
    wrap_up();
  end
endmodule
